/* hw/arq_top.sv */
// What this block does
// [RULE1] store responses to transmitted requests
// [RULE2] store foreign requests, never agent requests
// [RULE3] config and status at offset 30h
// [RULE4] host reads packets at offset 80h
// [RULE5] token quadlet with status, speed, ack first
// [RULE6] quadlet two: destination, tLabel, rt, tCode, prior
// [RULE7] quadlet format: source ID then rCode
// [RULE8] quadlet data fifth, only for carrying codes
// [RULE9] block: 48-bit offset in quadlets three/four
// [RULE10] block payload only for write req, read resp
// [RULE11] ack_complete gives status 0h
// [RULE12] split enabled plus ack_pnd gives 0h
// [RULE13] no acknowledge needed gives status 1h
// [RULE14] other acknowledge on request gives 2h
// [RULE15] ack_pnd on sent response gives 2h
// [RULE16] missing or broken acknowledge gives 3h
// [RULE17] invalid next-ORB pointer gives 4h
// [RULE18] valid next-ORB forwarded gives 5h
// [RULE19] speed code 00/01/10 for 100/200/400
// [RULE20] retry limit exceeded gives 7h
// [RULE21] priority field always zero
// [RULE22] one quadlet per read, arrival order
// [RULE23] status is top 4-bit token field
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "arq_consts.svh"
module arq_top #(
  parameter int DEPTH = 64
) (
  input wire logic CLOCK_IN,
  input wire logic SRST_IN,
  input wire logic [7:0] AWADDR_IN,
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  output logic [1:0] BRESP_OUT,
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic [7:0] ARADDR_IN,
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  input wire arq_pkg::arq_rx_info_t RX_INFO_IN,
  input wire logic RX_VALID_IN,
  output logic RX_READY_OUT,
  input wire logic [31:0] RX_DATA_IN,
  input wire logic RX_DATA_VALID_IN,
  output logic RX_DATA_READY_OUT
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  arq_pkg::arq_state_t st_reg;
  logic rx_ready_reg;
  logic pay_ready_reg;
  logic drop_reg;
  logic [2:0] idx_reg;
  logic [2:0] hdr_len_reg;
  logic [14:0] pay_left_reg;
  logic [31:0] hdr_reg [5];
  logic [31:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] cnt_reg;
  logic en_reg;
  logic split_reg;
  logic ovf_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic take;
  logic hi_flag;
  logic plain;
  logic busy_ack;
  logic pnd_wait;
  logic storable;
  logic is_block;
  logic fits;
  logic keep;
  logic [3:0] status_calc;
  logic [2:0] len_calc;
  logic [14:0] pay_calc;
  logic [16:0] len_round;
  logic wr_en;
  logic [31:0] wr_data;
  logic do_write;
  logic cfg_wr;
  logic flush_do;
  logic ar_take;
  logic [7:0] ar_word;
  logic pop;
  logic [31:0] sts_word;

  assign take = RX_VALID_IN && rx_ready_reg;
  assign hi_flag = RX_INFO_IN.orb_valid || RX_INFO_IN.orb_invalid ||
                   RX_INFO_IN.retry_over;
  assign plain = !hi_flag && !RX_INFO_IN.no_ack_needed &&
                 !RX_INFO_IN.ack_bad;
  assign busy_ack = RX_INFO_IN.ack == `ARQ_ACK_BUSY_X ||
                    RX_INFO_IN.ack == `ARQ_ACK_BUSY_A ||
                    RX_INFO_IN.ack == `ARQ_ACK_BUSY_B;
  // without split mode the later response is what gets queued
  assign pnd_wait = RX_INFO_IN.ack == `ARQ_ACK_PENDING &&
                    !RX_INFO_IN.tx_was_response && !split_reg; // [RULE12]
  assign storable = en_reg && !RX_INFO_IN.to_agent && // [RULE1] [RULE2]
                    !(plain && (busy_ack || pnd_wait));
  assign is_block = RX_INFO_IN.tcode == `ARQ_TC_WRB ||
                    RX_INFO_IN.tcode == `ARQ_TC_RDB ||
                    RX_INFO_IN.tcode == `ARQ_TC_RSB ||
                    RX_INFO_IN.tcode == `ARQ_TC_LKQ ||
                    RX_INFO_IN.tcode == `ARQ_TC_LKS;

  always_comb
  begin
    if (RX_INFO_IN.orb_valid)
      status_calc = `ARQ_ST_ORBSENT; // [RULE18]
    else if (RX_INFO_IN.orb_invalid)
      status_calc = `ARQ_ST_NOORB; // [RULE17]
    else if (RX_INFO_IN.retry_over)
      status_calc = `ARQ_ST_RETRY; // [RULE20]
    else if (RX_INFO_IN.no_ack_needed)
      status_calc = `ARQ_ST_NOACK; // [RULE13]
    else if (RX_INFO_IN.ack_bad)
      status_calc = `ARQ_ST_ACKBAD; // [RULE16]
    else if (RX_INFO_IN.ack == `ARQ_ACK_PENDING)
      status_calc = RX_INFO_IN.tx_was_response ? `ARQ_ST_ACKERR // [RULE15]
                                               : `ARQ_ST_DONE; // [RULE12]
    else if (RX_INFO_IN.ack == `ARQ_ACK_COMPLETE)
      status_calc = `ARQ_ST_DONE; // [RULE11]
    else
      status_calc = `ARQ_ST_ACKERR; // [RULE14]
  end

  always_comb
  begin
    len_round = {1'b0, RX_INFO_IN.data_length} + 17'h3;
    if (is_block)
      len_calc = `ARQ_LEN_DATA;
    else if (RX_INFO_IN.tcode == `ARQ_TC_WRQ ||
             RX_INFO_IN.tcode == `ARQ_TC_RSQ)
      len_calc = `ARQ_LEN_DATA; // [RULE8]
    else
      len_calc = `ARQ_LEN_HDR; // [RULE8]
    if (RX_INFO_IN.tcode == `ARQ_TC_WRB || RX_INFO_IN.tcode == `ARQ_TC_RSB)
      pay_calc = len_round[16:2]; // [RULE10]
    else
      pay_calc = 15'h0; // [RULE10]
  end

  // whole packet must fit, a partial entry would desync the reader
  assign fits = (17'(len_calc) + 17'(pay_calc)) <=
                (17'(DEPTH) - 17'(cnt_reg));
  assign keep = storable && fits;

  always_ff @(posedge CLOCK_IN)
  begin
    if (take)
    begin
      hdr_reg[0] <= {status_calc, 10'h0, RX_INFO_IN.spd, // [RULE5] [RULE23]
                     12'h0, RX_INFO_IN.ack}; // [RULE19]
      hdr_reg[1] <= {RX_INFO_IN.dest_id, RX_INFO_IN.tlabel, // [RULE6]
                     RX_INFO_IN.rt, RX_INFO_IN.tcode, 4'h0}; // [RULE21]
      if (is_block)
      begin
        hdr_reg[2] <= {RX_INFO_IN.src_id, RX_INFO_IN.offset[47:32]}; // [RULE9]
        hdr_reg[3] <= RX_INFO_IN.offset[31:0]; // [RULE9]
        hdr_reg[4] <= {RX_INFO_IN.data_length, RX_INFO_IN.ext_tcode};
      end
      else
      begin
        hdr_reg[2] <= {RX_INFO_IN.src_id, RX_INFO_IN.rcode, 12'h0}; // [RULE7]
        hdr_reg[3] <= 32'h0;
        hdr_reg[4] <= RX_INFO_IN.quad_data; // [RULE8]
      end
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      st_reg <= arq_pkg::ARQ_IDLE;
      rx_ready_reg <= 1'b1;
      pay_ready_reg <= 1'b0;
      drop_reg <= 1'b0;
      idx_reg <= 3'h0;
      hdr_len_reg <= `ARQ_LEN_HDR;
      pay_left_reg <= 15'h0;
    end
    else
    begin
      case (st_reg)
        arq_pkg::ARQ_IDLE:
          if (take)
          begin
            idx_reg <= 3'h0;
            hdr_len_reg <= len_calc;
            pay_left_reg <= pay_calc;
            drop_reg <= !keep; // [RULE2]
            if (keep)
            begin
              st_reg <= arq_pkg::ARQ_HDR; // [RULE1]
              rx_ready_reg <= 1'b0;
            end
            else if (pay_calc != 15'h0)
            begin
              // a refused block still has its payload drained
              st_reg <= arq_pkg::ARQ_PAY;
              rx_ready_reg <= 1'b0;
              pay_ready_reg <= 1'b1;
            end
          end
        arq_pkg::ARQ_HDR:
        begin
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == hdr_len_reg - 3'h1)
          begin
            if (pay_left_reg != 15'h0)
            begin
              st_reg <= arq_pkg::ARQ_PAY; // [RULE10]
              pay_ready_reg <= 1'b1;
            end
            else
            begin
              st_reg <= arq_pkg::ARQ_IDLE;
              rx_ready_reg <= 1'b1;
            end
          end
        end
        arq_pkg::ARQ_PAY:
          if (RX_DATA_VALID_IN)
          begin
            pay_left_reg <= pay_left_reg - 15'h1;
            if (pay_left_reg == 15'h1)
            begin
              st_reg <= arq_pkg::ARQ_IDLE;
              pay_ready_reg <= 1'b0;
              rx_ready_reg <= 1'b1;
            end
          end
        default:
          st_reg <= arq_pkg::ARQ_IDLE;
      endcase
    end
  end

  assign wr_en = (st_reg == arq_pkg::ARQ_HDR) ||
                 (st_reg == arq_pkg::ARQ_PAY && RX_DATA_VALID_IN && !drop_reg);
  assign wr_data = (st_reg == arq_pkg::ARQ_HDR) ? hdr_reg[idx_reg]
                                                : RX_DATA_IN;

  always_ff @(posedge CLOCK_IN)
  begin
    if (wr_en)
      mem[wr_ptr_reg] <= wr_data; // [RULE22]
  end

  // pointers wrap naturally, so DEPTH must be a power of two
  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN || flush_do)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (wr_en)
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + PW'(1); // [RULE22]
      cnt_reg <= cnt_reg + CW'(wr_en) - CW'(pop);
    end
  end

  assign do_write = aw_held_reg && w_held_reg;
  assign cfg_wr = do_write && {aw_addr_reg[7:2], 2'b00} == `ARQ_CFG_OFS &&
                  w_strb_reg[0]; // [RULE3]
  // flush is ignored unless the writer is idle, so no half packet is left behind
  assign flush_do = cfg_wr && w_data_reg[`ARQ_CFG_FLUSH] &&
                    st_reg == arq_pkg::ARQ_IDLE;

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ARQ_RESP_OKAY;
    end
    else
    begin
      if (AWVALID_IN && awready_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= AWADDR_IN;
        awready_reg <= 1'b0;
      end
      if (WVALID_IN && wready_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= WDATA_IN;
        w_strb_reg <= WSTRB_IN;
        wready_reg <= 1'b0;
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        if ({aw_addr_reg[7:2], 2'b00} == `ARQ_CFG_OFS ||
            {aw_addr_reg[7:2], 2'b00} == `ARQ_SPLIT_OFS ||
            {aw_addr_reg[7:2], 2'b00} == `ARQ_PORT_OFS)
          bresp_reg <= `ARQ_RESP_OKAY;
        else
          bresp_reg <= `ARQ_RESP_SLVERR;
      end
      if (bvalid_reg && BREADY_IN)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      en_reg <= `ARQ_CFG_RST_EN;
      split_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end
    else
    begin
      if (cfg_wr)
        en_reg <= w_data_reg[`ARQ_CFG_EN]; // [RULE3]
      if (do_write && w_strb_reg[0] &&
          {aw_addr_reg[7:2], 2'b00} == `ARQ_SPLIT_OFS)
        split_reg <= w_data_reg[`ARQ_SPLIT_BIT]; // [RULE12]
      // a new overflow beats a clear in the same cycle
      if (take && storable && !fits)
        ovf_reg <= 1'b1;
      else if (cfg_wr && w_data_reg[`ARQ_CFG_OVF])
        ovf_reg <= 1'b0;
    end
  end

  assign ar_take = ARVALID_IN && arready_reg;
  assign ar_word = {ARADDR_IN[7:2], 2'b00};
  assign pop = ar_take && ar_word == `ARQ_PORT_OFS && // [RULE4]
               cnt_reg != '0 && !flush_do;
  assign sts_word = {16'(cnt_reg), 6'h0, cnt_reg == CW'(DEPTH),
                     cnt_reg == '0, 5'h0, ovf_reg, 1'b0, en_reg}; // [RULE3]

  always_ff @(posedge CLOCK_IN)
  begin
    if (SRST_IN)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `ARQ_RESP_OKAY;
    end
    else
    begin
      if (ar_take)
      begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rresp_reg <= `ARQ_RESP_OKAY;
        if (ar_word == `ARQ_CFG_OFS)
          rdata_reg <= sts_word;
        else if (ar_word == `ARQ_SPLIT_OFS)
          rdata_reg <= {31'h0, split_reg};
        else if (ar_word == `ARQ_PORT_OFS)
          rdata_reg <= pop ? mem[rd_ptr_reg] : 32'h0; // [RULE22]
        else
        begin
          rdata_reg <= 32'h0;
          rresp_reg <= `ARQ_RESP_SLVERR;
        end
      end
      if (rvalid_reg && RREADY_IN)
      begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign AWREADY_OUT = awready_reg;
  assign WREADY_OUT = wready_reg;
  assign BVALID_OUT = bvalid_reg;
  assign BRESP_OUT = bresp_reg;
  assign ARREADY_OUT = arready_reg;
  assign RVALID_OUT = rvalid_reg;
  assign RDATA_OUT = rdata_reg;
  assign RRESP_OUT = rresp_reg;
  assign RX_READY_OUT = rx_ready_reg;
  assign RX_DATA_READY_OUT = pay_ready_reg;

  a_agent_dropped: assert property ( // [RULE2]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take && RX_INFO_IN.to_agent |=> drop_reg && st_reg != arq_pkg::ARQ_HDR)
    else $error("agent request was queued");
  a_kept_stored: assert property ( // [RULE1]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take && keep |=> st_reg == arq_pkg::ARQ_HDR ##1 wr_en)
    else $error("storable packet not written");
  a_token_fields: assert property ( // [RULE5] [RULE19]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take |=> hdr_reg[0][`ARQ_TOK_SPD] == $past(RX_INFO_IN.spd) &&
      hdr_reg[0][`ARQ_TOK_ACK] == $past(RX_INFO_IN.ack))
    else $error("token speed or ack wrong");
  a_status_done: assert property ( // [RULE11] [RULE12]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take && plain && (RX_INFO_IN.ack == `ARQ_ACK_COMPLETE ||
      (RX_INFO_IN.ack == `ARQ_ACK_PENDING && split_reg &&
       !RX_INFO_IN.tx_was_response))
    |=> hdr_reg[0][`ARQ_TOK_STS] == `ARQ_ST_DONE)
    else $error("completion status not 0h");
  a_status_ackerr: assert property ( // [RULE15]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take && plain && RX_INFO_IN.ack == `ARQ_ACK_PENDING &&
    RX_INFO_IN.tx_was_response |=> hdr_reg[0][`ARQ_TOK_STS] == `ARQ_ST_ACKERR)
    else $error("pending on response not 2h");
  a_status_noack: assert property ( // [RULE13] [RULE16]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take && !hi_flag && (RX_INFO_IN.no_ack_needed || RX_INFO_IN.ack_bad)
    |=> hdr_reg[0][`ARQ_TOK_STS] == ($past(RX_INFO_IN.no_ack_needed) ?
        `ARQ_ST_NOACK : `ARQ_ST_ACKBAD))
    else $error("ack absence status wrong");
  a_status_fetch: assert property ( // [RULE17] [RULE18] [RULE20]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take && hi_flag |=> hdr_reg[0][`ARQ_TOK_STS] ==
      ($past(RX_INFO_IN.orb_valid) ? `ARQ_ST_ORBSENT :
       $past(RX_INFO_IN.orb_invalid) ? `ARQ_ST_NOORB : `ARQ_ST_RETRY))
    else $error("fetch or retry status wrong");
  a_prior_zero: assert property ( // [RULE21]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    wr_en && st_reg == arq_pkg::ARQ_HDR && idx_reg == `ARQ_Q1_IDX
    |-> wr_data[`ARQ_Q1_PRIO] == 4'h0)
    else $error("priority field not zero");
  a_quad_len: assert property ( // [RULE8] [RULE10]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    take && keep && (RX_INFO_IN.tcode == `ARQ_TC_RDQ ||
      RX_INFO_IN.tcode == `ARQ_TC_WRS || RX_INFO_IN.tcode == `ARQ_TC_RDB)
    |=> pay_left_reg == 15'h0 && hdr_len_reg ==
      ($past(RX_INFO_IN.tcode) == `ARQ_TC_RDB ? `ARQ_LEN_DATA : `ARQ_LEN_HDR))
    else $error("no-data packet length wrong");
  a_pop_order: assert property ( // [RULE22]
    @(posedge CLOCK_IN) disable iff (SRST_IN)
    pop |=> rd_ptr_reg == $past(rd_ptr_reg) + PW'(1) &&
      cnt_reg == $past(cnt_reg) + CW'($past(wr_en)) - CW'(1))
    else $error("read port pop out of order");
endmodule // arq_top

/* hw/arq_consts.svh */
`ifndef ARQ_CONSTS_SVH
`define ARQ_CONSTS_SVH
`define ARQ_SPLIT_OFS 8'h08
`define ARQ_CFG_OFS 8'h30
`define ARQ_PORT_OFS 8'h80
`define ARQ_RESP_OKAY 2'h0
`define ARQ_RESP_SLVERR 2'h2
`define ARQ_CFG_EN 0
`define ARQ_CFG_FLUSH 1
`define ARQ_CFG_OVF 2
`define ARQ_SPLIT_BIT 0
`define ARQ_CFG_RST_EN 1'h1
`define ARQ_ACK_COMPLETE 4'h1
`define ARQ_ACK_PENDING 4'h2
`define ARQ_ACK_BUSY_X 4'h4
`define ARQ_ACK_BUSY_A 4'h5
`define ARQ_ACK_BUSY_B 4'h6
`define ARQ_ST_DONE 4'h0
`define ARQ_ST_NOACK 4'h1
`define ARQ_ST_ACKERR 4'h2
`define ARQ_ST_ACKBAD 4'h3
`define ARQ_ST_NOORB 4'h4
`define ARQ_ST_ORBSENT 4'h5
`define ARQ_ST_RETRY 4'h7
`define ARQ_TC_WRQ 4'h0
`define ARQ_TC_WRB 4'h1
`define ARQ_TC_WRS 4'h2
`define ARQ_TC_RDQ 4'h4
`define ARQ_TC_RDB 4'h5
`define ARQ_TC_RSQ 4'h6
`define ARQ_TC_RSB 4'h7
`define ARQ_TC_LKQ 4'h9
`define ARQ_TC_LKS 4'hb
`define ARQ_TOK_STS 31:28
`define ARQ_TOK_SPD 17:16
`define ARQ_TOK_ACK 3:0
`define ARQ_Q1_PRIO 3:0
`define ARQ_LEN_HDR 3'h4
`define ARQ_LEN_DATA 3'h5
`define ARQ_Q1_IDX 3'h1
`endif

/* hw/arq_pkg.sv */
package arq_pkg;
  typedef struct packed {
    logic to_agent;
    logic tx_was_response;
    logic no_ack_needed;
    logic ack_bad;
    logic retry_over;
    logic orb_valid;
    logic orb_invalid;
    logic [1:0] spd;
    logic [3:0] ack;
    logic [15:0] dest_id;
    logic [5:0] tlabel;
    logic [1:0] rt;
    logic [3:0] tcode;
    logic [15:0] src_id;
    logic [3:0] rcode;
    logic [47:0] offset;
    logic [15:0] data_length;
    logic [15:0] ext_tcode;
    logic [31:0] quad_data;
  } arq_rx_info_t;

  typedef enum logic [2:0] {
    ARQ_IDLE = 3'b001,
    ARQ_HDR = 3'b010,
    ARQ_PAY = 3'b100
  } arq_state_t;
endpackage

/* test/arq_rx_src.sv */
`timescale 1ns/100ps
module arq_rx_src (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic stall_in,
  input wire arq_pkg::arq_rx_info_t info_in,
  input wire logic [7:0] nq_in,
  input wire logic rx_ready_in,
  input wire logic data_ready_in,
  output arq_pkg::arq_rx_info_t info_out,
  output logic valid_out,
  output logic [31:0] data_out,
  output logic data_valid_out,
  output logic busy_out
);
  logic [7:0] left_reg;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      valid_out <= 1'b0;
      data_valid_out <= 1'b0;
      busy_out <= 1'b0;
      left_reg <= 8'h00;
      data_out <= 32'h0;
      info_out <= '0;
    end
    else if (go_in && !busy_out)
    begin
      info_out <= info_in;
      valid_out <= 1'b1;
      busy_out <= 1'b1;
      left_reg <= nq_in;
    end
    else if (valid_out && rx_ready_in)
    begin
      valid_out <= 1'b0;
      // fields only hold to the take edge, so scramble them after
      info_out <= ~info_out;
    end
    else if (data_valid_out && data_ready_in)
    begin
      left_reg <= left_reg - 8'h01;
      data_valid_out <= 1'b0;
      data_out <= ~data_out;
    end
    else if (busy_out && !valid_out && !data_valid_out)
    begin
      if (left_reg == 8'h00)
        busy_out <= 1'b0;
      else if (!stall_in)
      begin
        // counting-down pattern makes order slips visible
        data_valid_out <= 1'b1;
        data_out <= {24'ha5a5a5, left_reg};
      end
    end
  end
endmodule // arq_rx_src

/* test/tb.sv */
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rx_data, d;
  logic [1:0] r;
  arq_pkg::arq_rx_info_t rx_info;
  arq_pkg::arq_rx_info_t s_info = '0;
  arq_pkg::arq_rx_info_t pk;
  logic rx_valid, rx_ready, rx_dv, rx_dr, s_busy;
  logic go = 1'b0;
  logic stall_mode = 1'b0;
  logic stall = 1'b0;
  logic [7:0] s_nq = 8'h00;
  int failures = 0;
  int n_compared = 0;
  logic [3:0] tc_t [8] = '{4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h6, 4'h5, 4'h4};
  logic [3:0] ak_t [8] = '{4'h2, 4'h1, 4'h1, 4'h1, 4'h0, 4'h2, 4'h1, 4'h1};
  logic [6:0] fl_t [8] = '{7'h00, 7'h02, 7'h01, 7'h04, 7'h08, 7'h20, 7'h00,
                           7'h10};
  logic [3:0] st_t [8] = '{4'h0, 4'h5, 4'h4, 4'h7, 4'h3, 4'h2, 4'h0, 4'h1};
  int ln_t [8] = '{4, 4, 4, 4, 4, 5, 5, 4};

  always #2 clk = ~clk;
  always @(posedge clk) stall <= stall_mode & ~stall;

  arq_top #(.DEPTH(64)) dut (
    .CLOCK_IN(clk), .SRST_IN(rst),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid),
    .BREADY_IN(bready), .ARADDR_IN(araddr), .ARVALID_IN(arvalid),
    .ARREADY_OUT(arready), .RDATA_OUT(rdata), .RRESP_OUT(rresp),
    .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RX_INFO_IN(rx_info), .RX_VALID_IN(rx_valid), .RX_READY_OUT(rx_ready),
    .RX_DATA_IN(rx_data), .RX_DATA_VALID_IN(rx_dv),
    .RX_DATA_READY_OUT(rx_dr)
  );

  arq_rx_src src (
    .clk_in(clk), .rst_in(rst), .go_in(go), .stall_in(stall),
    .info_in(s_info), .nq_in(s_nq), .rx_ready_in(rx_ready),
    .data_ready_in(rx_dr), .info_out(rx_info), .valid_out(rx_valid),
    .data_out(rx_data), .data_valid_out(rx_dv), .busy_out(s_busy)
  );

  task summarize;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task hang;
    failures++;
    summarize();
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // readies are sampled at the falling edge, where they are settled
  // bready and rready stay up between transfers: no double assignment
  task automatic wr(input logic [7:0] a, input logic [31:0] dv,
                    output logic [1:0] rs);
    int n;
    logic ta, tw, done;
    n = 0;
    done = 1'b0;
    rs = 2'h3;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dv;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(negedge clk);
      ta = awready & awvalid;
      tw = wready & wvalid;
      done = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      n++;
      if (n > 100)
        hang();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dv,
                    output logic [1:0] rs);
    int n;
    logic ta, done;
    n = 0;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(negedge clk);
      ta = arready & arvalid;
      done = rvalid;
      dv = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
      n++;
      if (n > 100)
        hang();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] dv;
    logic [1:0] rs;
    rd(a, dv, rs);
    chk(dv, exp);
  endtask

  task automatic send(input arq_pkg::arq_rx_info_t i, input logic [7:0] nq);
    int n;
    logic idle;
    s_info <= i;
    s_nq <= nq;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    idle = 1'b0;
    n = 0;
    while (!idle)
    begin
      @(negedge clk);
      idle = !s_busy && rx_ready;
      @(posedge clk);
      n++;
      if (n > 200)
        hang();
    end
  endtask

  function automatic arq_pkg::arq_rx_info_t mk(input logic [3:0] tc,
      input logic [3:0] ak, input logic [6:0] f);
    mk = '0;
    {mk.to_agent, mk.tx_was_response, mk.no_ack_needed, mk.ack_bad,
     mk.retry_over, mk.orb_valid, mk.orb_invalid} = f;
    mk.tcode = tc;
    mk.ack = ak;
    mk.spd = 2'h2;
    mk.dest_id = 16'h1234;
    mk.tlabel = 6'h2a;
    mk.rt = 2'h1;
    mk.src_id = 16'hffc1;
    mk.rcode = 4'h5;
    mk.offset = 48'hfedc_ba98_7650;
    mk.data_length = 16'h0008;
    mk.quad_data = 32'hcafe_0001;
  endfunction

  // 400 Mbps receive rate is code 10
  function automatic logic [31:0] tok(input logic [3:0] st,
                                      input logic [3:0] ak);
    return {st, 10'h0, 2'h2, 12'h0, ak};
  endfunction

  function automatic logic [31:0] q1x(input logic [3:0] tc);
    return {16'h1234, 6'h2a, 2'h1, tc, 4'h0};
  endfunction

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(8'h30, 32'h0000_0101);
    rdc(8'h08, 32'h0);
    rd(8'h80, d, r);
    chk({d[29:0], r}, 32'h0);
    rd(8'h44, d, r);
    chk({30'h0, r}, 32'h2);
    wr(8'h44, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    wr(8'h80, 32'h1, r);
    chk({30'h0, r}, 32'h0);
    $display("test registers done");

    send(mk(4'h0, 4'h1, 7'h00), 8'h00);
    rdc(8'h30, 32'h0005_0001);
    rdc(8'h80, tok(4'h0, 4'h1));
    rdc(8'h80, q1x(4'h0));
    rdc(8'h80, 32'hffc1_5000);
    rdc(8'h80, 32'h0);
    rdc(8'h80, 32'hcafe_0001);
    rdc(8'h30, 32'h0000_0101);
    $display("test quadlet write done");

    stall_mode <= 1'b1;
    send(mk(4'h1, 4'hd, 7'h00), 8'h02);
    stall_mode <= 1'b0;
    rdc(8'h80, tok(4'h2, 4'hd));
    rdc(8'h80, q1x(4'h1));
    rdc(8'h80, 32'hffc1_fedc);
    rdc(8'h80, 32'hba98_7650);
    rdc(8'h80, 32'h0008_0000);
    rdc(8'h80, 32'ha5a5_a502);
    rdc(8'h80, 32'ha5a5_a501);
    rdc(8'h80, 32'h0);
    $display("test block write done");

    wr(8'h08, 32'h1, r);
    for (int i = 0; i < 8; i++)
      send(mk(tc_t[i], ak_t[i], fl_t[i]), 8'h00);
    rdc(8'h30, 32'h0022_0001);
    for (int i = 0; i < 8; i++)
    begin
      rdc(8'h80, tok(st_t[i], ak_t[i]));
      for (int j = 1; j < ln_t[i]; j++)
        rd(8'h80, d, r);
    end
    rdc(8'h30, 32'h0000_0101);
    $display("test status codes done");

    wr(8'h08, 32'h0, r);
    send(mk(4'h4, 4'h2, 7'h00), 8'h00);
    send(mk(4'h4, 4'h1, 7'h40), 8'h00);
    rdc(8'h30, 32'h0000_0101);
    wr(8'h30, 32'h0, r);
    send(mk(4'h1, 4'h1, 7'h00), 8'h02);
    rdc(8'h30, 32'h0000_0100);
    wr(8'h30, 32'h1, r);
    rdc(8'h30, 32'h0000_0101);
    $display("test refusals done");
    send(mk(4'h4, 4'h4, 7'h00), 8'h00);
    rdc(8'h30, 32'h0000_0101);
    // 5 header plus 59 payload quadlets fill a 64-entry queue exactly
    pk = mk(4'h1, 4'h1, 7'h00);
    pk.data_length = 16'h00ec;
    send(pk, 8'h3b);
    rdc(8'h30, 32'h0040_0201);
    send(mk(4'h4, 4'h1, 7'h00), 8'h00);
    rdc(8'h30, 32'h0040_0205);
    rdc(8'h80, tok(4'h0, 4'h1));
    wr(8'h30, 32'h7, r);
    rdc(8'h30, 32'h0000_0101);
    $display("test busy, overflow and flush done");
    summarize();
  end
endmodule // tb
